// >>> logic/boot_resp_pkg.sv
/*
 * Constants for the serial boot command responder: command codes,
 * acknowledgement fields, reply codes and the fixed information record.
 * Assumes the flash is seen as a byte array starting at its first address.
 */
`default_nettype none

package boot_resp_pkg;

	localparam int BYTE_W = 8;
	localparam int FIFO_DEPTH = 4;
	localparam int ADDR_W = 20;
	localparam int FLASH_ADDR_W = 19;
	localparam int FLASH_BYTES_DEFAULT = 524288;

	localparam logic [7:0] MODE_BYTE = 8'h86;
	localparam logic [7:0] CMD_SUM = 8'h20;
	localparam logic [7:0] CMD_INFO = 8'h30;
	localparam logic [7:0] CMD_ERASE = 8'h40;

	localparam logic [3:0] ACK_RX_ERR = 4'h8;
	localparam logic [3:0] ACK_BAD_CMD = 4'h1;
	localparam logic [3:0] NIB_RESET = 4'h0;

	localparam logic [7:0] ERASE_END = 8'h4f;
	localparam logic [7:0] ERASE_FAIL = 8'h4c;
	localparam logic [7:0] ERASE_ACK_OK = 8'hb1;
	localparam logic [7:0] ERASE_ACK_ERR = 8'hb4;

	localparam logic [7:0] PROT_ANY = 8'h01;
	localparam logic [7:0] PROT_NONE = 8'h03;

	// software id bytes, offset from the flash start
	localparam logic [19:0] ID_OFFSET = 20'h7fef0;

	// info record index = reply byte number minus five
	localparam logic [6:0] ID_LAST_IDX = 7'h03;
	localparam logic [6:0] NAME_FIRST_IDX = 7'h04;
	localparam logic [6:0] NAME_LAST_IDX = 7'h0f;
	localparam logic [6:0] PROT_IDX = 7'h29;
	localparam logic [6:0] INFO_LAST_IDX = 7'h4f;

	// product name, value arbitrary; last character a space
	localparam logic [95:0] PRODUCT_NAME = "BOOTTARGET1 ";

	localparam logic [7:0] INFO_ROM [0:79] = '{
		8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'hf4, 8'hfe, 8'h08, 8'h00,
		8'h00, 8'h04, 8'h00, 8'h00,
		8'hff, 8'h6b, 8'h00, 8'h00,
		8'hff, 8'h83, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00,
		8'h00, 8'h00, 8'h01, 8'h00,
		8'hff, 8'hff, 8'h08, 8'h00,
		8'h0a, 8'h00,
		8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h06,
		8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h70, 8'h00, 8'h00, 8'h02,
		8'h00, 8'hc0, 8'h08, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h02,
		8'h00
	};

endpackage

`default_nettype wire

// >>> logic/boot_serial_responder.sv
/*
 * Target-side responder of a byte serial boot protocol: mode byte echo,
 * flash sum report, product information report and chip erase request.
 * Assumes a same-clock byte receiver with an error flag, a byte
 * transmitter with valid/ready, a flash read port with one cycle of
 * latency and an external erase engine.
 */
// Contract
// - ack upper nibble equals last valid command nibble
// - receive error answers x8, await command
// - unknown command answers x1, await command
// - valid command echoed, then its routine
// - 20h echoed, starts flash sum
// - sum sent high byte then low byte
// - seventh byte is negated sum-byte total
// - 30h echoed, starts information report
// - bytes 5-8 read from id flash bytes
// - bytes 9-20 product name ending space
// - bytes 21-24 password start address
// - bytes 25-32 ram start, user ram end
// - bytes 33-36 ram end, then dummy filler
// - bytes 45-46 report protection state
// - bytes 47-54 flash start and end
// - bytes 55-56 flash block count
// - bytes 57-83 three block group records
// - byte 84 negated sum of bytes 5-83
// - 40h echoed, starts chip erase
// - fifth byte 4Fh ok, 4Ch error
// - sixth byte B1h ok, B4h error
// - ack bits 1,2 zero; 3 rx error; 0 fault
// - sum of all flash bytes, 16 bits
`default_nettype none

module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = PTR_W + 1;
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [CNT_W-1:0] count_reg;
	wire do_wr;
	wire do_rd;
	wire [PTR_W-1:0] wr_ptr_next;
	wire [PTR_W-1:0] rd_ptr_next;

	assign in_ready = count_reg != CNT_FULL;
	assign out_valid = count_reg != '0;
	assign out_data = mem[rd_ptr_reg];
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;
	assign wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
	assign rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;

	always_ff @(posedge ref_clk) begin
		if (do_wr) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_reg <= wr_ptr_next;
			end
			if (do_rd) begin
				rd_ptr_reg <= rd_ptr_next;
			end
			if (do_wr && !do_rd) begin
				count_reg <= count_reg + 1'b1;
			end else if (do_rd && !do_wr) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

endmodule // byte_fifo

module boot_serial_responder
	import boot_resp_pkg::*;
#(
	parameter int FLASH_BYTES = FLASH_BYTES_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	input wire logic rx_error,
	output logic rx_ready,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [FLASH_ADDR_W-1:0] flash_addr,
	output logic flash_rd_en,
	input wire logic [7:0] flash_rd_data,
	output logic erase_start,
	input wire logic erase_done,
	input wire logic erase_ok,
	input wire logic any_protected
);

	typedef enum logic [10:0] {
		S_MODE = 11'h001,
		S_CMD = 11'h002,
		S_SEND = 11'h004,
		S_SUM_RUN = 11'h008,
		S_SUM_LO = 11'h010,
		S_SUM_CK = 11'h020,
		S_INFO_RD = 11'h040,
		S_INFO_GET = 11'h080,
		S_ERASE_GO = 11'h100,
		S_ERASE_WAIT = 11'h200,
		S_ERASE_B = 11'h400
	} state_e;

	localparam logic [ADDR_W-1:0] ADDR_END = ADDR_W'(FLASH_BYTES);

	function automatic logic [7:0] checksum(input logic [7:0] total);
		checksum = 8'h00 - total;
	endfunction

	// constant record bytes with name and protection filled in
	function automatic logic [7:0] info_byte(input logic [6:0] idx,
			input logic prot);
		logic [3:0] pos;
		pos = 4'(NAME_LAST_IDX - idx);
		if (idx >= NAME_FIRST_IDX && idx <= NAME_LAST_IDX) begin
			info_byte = PRODUCT_NAME[pos*8 +: 8];
		end else if (idx == PROT_IDX) begin
			info_byte = prot ? PROT_ANY : PROT_NONE;
		end else begin
			info_byte = INFO_ROM[idx];
		end
	endfunction

	state_e state_reg, state_next;
	state_e ret_reg, ret_next;
	logic [7:0] out_reg, out_next;
	logic [3:0] nib_reg, nib_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic pend_reg, pend_next;
	logic [15:0] sum_reg, sum_next;
	logic [6:0] idx_reg, idx_next;
	logic [7:0] ck_reg, ck_next;
	logic ok_reg, ok_next;

	wire fifo_in_ready;
	wire push;
	wire rx_take;
	wire cmd_known;
	wire sum_more;
	wire id_phase;
	wire [7:0] sum_byte_total;
	wire [7:0] info_const;
	wire [7:0] info_data;
	wire [7:0] info_out;
	wire [15:0] sum_added;
	wire is_sum;
	wire is_info;
	wire is_erase;
	wire mode_ok;
	wire sum_done;
	wire info_last;
	wire [7:0] ack_rx_err;
	wire [7:0] ack_bad_cmd;
	wire [7:0] sum_ck;
	wire [7:0] erase_code;
	wire [7:0] erase_ack;

	assign push = state_reg == S_SEND;
	// commands refused while a routine runs
	assign rx_ready = (state_reg == S_MODE) || (state_reg == S_CMD);
	assign rx_take = rx_valid && rx_ready;
	assign is_sum = rx_data == CMD_SUM;
	assign is_info = rx_data == CMD_INFO;
	assign is_erase = rx_data == CMD_ERASE;
	assign cmd_known = is_sum || is_info || is_erase;
	assign mode_ok = !rx_error && (rx_data == MODE_BYTE);
	// error answers keep the nibble of the last good command
	assign ack_rx_err = {nib_reg, ACK_RX_ERR};
	assign ack_bad_cmd = {nib_reg, ACK_BAD_CMD};
	assign sum_more = addr_reg != ADDR_END;
	assign id_phase = idx_reg <= ID_LAST_IDX;
	assign flash_rd_en = ((state_reg == S_SUM_RUN) && sum_more)
		|| ((state_reg == S_INFO_RD) && id_phase);
	assign flash_addr = addr_reg[FLASH_ADDR_W-1:0];
	assign erase_start = state_reg == S_ERASE_GO;
	assign sum_added = sum_reg + {8'h00, flash_rd_data};
	assign sum_byte_total = sum_reg[15:8] + sum_reg[7:0];
	assign sum_ck = checksum(sum_byte_total);
	// last read still in flight until pend_reg drops
	assign sum_done = !flash_rd_en && !pend_reg;
	assign erase_code = erase_ok ? ERASE_END : ERASE_FAIL;
	assign erase_ack = ok_reg ? ERASE_ACK_OK : ERASE_ACK_ERR;
	assign info_last = idx_reg == INFO_LAST_IDX;
	assign info_const = info_byte(idx_reg, any_protected);
	// first four record bytes come from flash
	assign info_data = id_phase ? flash_rd_data : info_const;
	assign info_out = info_last ? checksum(ck_reg) : info_data;

	always_comb begin
		state_next = state_reg;
		ret_next = ret_reg;
		out_next = out_reg;
		nib_next = nib_reg;
		addr_next = addr_reg;
		pend_next = 1'b0;
		sum_next = sum_reg;
		idx_next = idx_reg;
		ck_next = ck_reg;
		ok_next = ok_reg;
		case (state_reg)
			S_MODE: begin
				// wrong byte or error: stay silent, as after a failed rate
				if (rx_take && mode_ok) begin
					out_next = rx_data;
					ret_next = S_CMD;
					state_next = S_SEND;
				end
			end
			S_CMD: begin
				if (rx_take) begin
					state_next = S_SEND;
					ret_next = S_CMD;
					if (rx_error) begin
						out_next = ack_rx_err;
					end else if (cmd_known) begin
						nib_next = rx_data[7:4];
						out_next = rx_data;
						if (is_sum) begin
							ret_next = S_SUM_RUN;
							addr_next = '0;
							sum_next = '0;
						end else if (is_info) begin
							ret_next = S_INFO_RD;
							addr_next = ID_OFFSET;
							idx_next = '0;
							ck_next = '0;
						end else begin
							ret_next = S_ERASE_GO;
						end
					end else begin
						out_next = ack_bad_cmd;
					end
				end
			end
			S_SEND: begin
				if (fifo_in_ready) begin
					state_next = ret_reg;
				end
			end
			S_SUM_RUN: begin
				pend_next = flash_rd_en;
				if (flash_rd_en) begin
					addr_next = addr_reg + 1'b1;
				end
				if (pend_reg) begin
					sum_next = sum_added;
				end
				if (sum_done) begin
					out_next = sum_reg[15:8];
					ret_next = S_SUM_LO;
					state_next = S_SEND;
				end
			end
			S_SUM_LO: begin
				out_next = sum_reg[7:0];
				ret_next = S_SUM_CK;
				state_next = S_SEND;
			end
			S_SUM_CK: begin
				out_next = sum_ck;
				ret_next = S_CMD;
				state_next = S_SEND;
			end
			S_INFO_RD: begin
				state_next = S_INFO_GET;
			end
			S_INFO_GET: begin
				out_next = info_out;
				ck_next = ck_reg + info_data;
				idx_next = idx_reg + 1'b1;
				addr_next = addr_reg + 1'b1;
				ret_next = info_last ? S_CMD : S_INFO_RD;
				state_next = S_SEND;
			end
			S_ERASE_GO: begin
				state_next = S_ERASE_WAIT;
			end
			S_ERASE_WAIT: begin
				if (erase_done) begin
					ok_next = erase_ok;
					out_next = erase_code;
					ret_next = S_ERASE_B;
					state_next = S_SEND;
				end
			end
			S_ERASE_B: begin
				out_next = erase_ack;
				ret_next = S_CMD;
				state_next = S_SEND;
			end
			default: begin
				state_next = S_MODE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_reg <= S_MODE;
			ret_reg <= S_MODE;
			out_reg <= 8'h00;
			nib_reg <= NIB_RESET;
			addr_reg <= '0;
			pend_reg <= 1'b0;
			sum_reg <= 16'h0000;
			idx_reg <= 7'h00;
			ck_reg <= 8'h00;
			ok_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ret_reg <= ret_next;
			out_reg <= out_next;
			nib_reg <= nib_next;
			addr_reg <= addr_next;
			pend_reg <= pend_next;
			sum_reg <= sum_next;
			idx_reg <= idx_next;
			ck_reg <= ck_next;
			ok_reg <= ok_next;
		end
	end

	// reply bytes queue here; a stalled transmitter holds the machine
	byte_fifo #(
		.WIDTH(BYTE_W),
		.DEPTH(FIFO_DEPTH)
	) tx_queue (
		.ref_clk(ref_clk),
		.reset(reset),
		.in_data(out_reg),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.out_data(tx_data),
		.out_valid(tx_valid),
		.out_ready(tx_ready)
	);

endmodule // boot_serial_responder

`default_nettype wire

// >>> testbench/flash_erase_model.sv
/* flash read port and erase engine seen by the responder.
   assumes one cycle read latency and a settable erase delay. */
`default_nettype none
module flash_erase_model
	import boot_resp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [FLASH_ADDR_W-1:0] flash_addr,
	input wire logic flash_rd_en,
	output logic [7:0] flash_rd_data,
	input wire logic erase_start,
	input wire logic ok_in,
	input wire logic [7:0] delay,
	output logic erase_done,
	output logic erase_ok
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_reg = 8'h00;
	initial begin
		flash_rd_data = 8'h00;
		erase_done = 1'b0;
		erase_ok = 1'b0;
	end
	// idle read data flips so stale bytes never match
	always @(posedge ref_clk) begin
		flash_rd_data <= flash_rd_en ? flash_addr[7:0] * 8'h13 + 8'ha1 :
			~flash_rd_data;
		erase_done <= cnt_reg == 8'h01;
		erase_ok <= (cnt_reg == 8'h01) ? ok_in : ~ok_in;
		cnt_reg <= erase_start ? delay : cnt_reg - 8'(cnt_reg != 8'h00);
	end
endmodule // flash_erase_model
`default_nettype wire

// >>> testbench/boot_resp_assertions.sv
/* port checker for the boot responder.
   assumes the host keeps tx_ready high while an erase ends. */
`default_nettype none
module boot_resp_checker
	import boot_resp_pkg::*;
#(parameter int FLASH_BYTES = 8) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	input wire logic rx_error,
	input wire logic rx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [FLASH_ADDR_W-1:0] flash_addr,
	input wire logic flash_rd_en,
	input wire logic [7:0] flash_rd_data,
	input wire logic erase_start,
	input wire logic erase_done,
	input wire logic erase_ok,
	input wire logic any_protected
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	logic seen_reg, wait_reg, ok_reg;
	logic [3:0] nib_reg;
	wire logic take = rx_valid && rx_ready;
	wire logic good = rx_data == CMD_SUM || rx_data == CMD_INFO ||
		rx_data == CMD_ERASE;
	wire logic cmd = take && seen_reg && !tx_valid;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			seen_reg <= 1'b0;
			wait_reg <= 1'b0;
			ok_reg <= 1'b0;
			nib_reg <= NIB_RESET;
		end else begin
			if (take && !rx_error && rx_data == MODE_BYTE)
				seen_reg <= 1'b1;
			if (take && seen_reg && !rx_error && good)
				nib_reg <= rx_data[7:4];
			if (erase_start)
				wait_reg <= 1'b1;
			else if (erase_done)
				wait_reg <= 1'b0;
			if (wait_reg && erase_done)
				ok_reg <= erase_ok;
		end
	end
	sequence s_erase_reply;
		##2 tx_valid && tx_data == (ok_reg ? ERASE_END : ERASE_FAIL)
		##2 tx_valid && tx_data == (ok_reg ? ERASE_ACK_OK : ERASE_ACK_ERR);
	endsequence
	chk_idle_after_rst: assert property ($fell(reset) |-> !tx_valid &&
		!erase_start && !flash_rd_en && flash_addr == '0)
		else $error("outputs busy after reset");
	chk_mode_drop: assert property (
		!seen_reg && take && (rx_error || rx_data != MODE_BYTE) |=>
		rx_ready ##1 !tx_valid) else $error("bad mode byte answered");
	chk_rx_err_ack: assert property (
		cmd && rx_error |-> ##2 tx_valid && tx_data == {nib_reg, ACK_RX_ERR})
		else $error("receive error ack wrong");
	chk_bad_cmd_ack: assert property (
		cmd && !rx_error && !good |-> ##2 tx_valid &&
		tx_data == {nib_reg, ACK_BAD_CMD}) else $error("bad command ack wrong");
	chk_cmd_echo: assert property (
		cmd && !rx_error && good |-> ##2 tx_valid &&
		tx_data == $past(rx_data, 2)) else $error("command not echoed");
	chk_rx_busy: assert property (take && seen_reg |=> !rx_ready)
		else $error("command taken while busy");
	chk_erase_go: assert property (
		cmd && !rx_error && rx_data == CMD_ERASE |-> ##2 erase_start ##1
		!erase_start) else $error("erase start pulse wrong");
	chk_erase_end: assert property (
		wait_reg && erase_done && !tx_valid && tx_ready |-> s_erase_reply)
		else $error("erase result bytes wrong");
	chk_sum_addr: assert property (
		flash_rd_en && $past(flash_rd_en) |->
		flash_addr == $past(flash_addr) + 1'b1) else $error("sum address skip");
	chk_tx_hold: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data)) else $error("tx byte not held");
endmodule // boot_resp_checker
bind boot_serial_responder boot_resp_checker #(.FLASH_BYTES(FLASH_BYTES))
	u_chk (.ref_clk(ref_clk), .reset(reset), .rx_data(rx_data),
	.rx_valid(rx_valid), .rx_error(rx_error), .rx_ready(rx_ready),
	.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
	.flash_addr(flash_addr), .flash_rd_en(flash_rd_en),
	.flash_rd_data(flash_rd_data), .erase_start(erase_start),
	.erase_done(erase_done), .erase_ok(erase_ok),
	.any_protected(any_protected));
`default_nettype wire

// >>> testbench/tb_top.sv
/* self-checking bench: host side of the boot responder.
   assumes the flash model data pattern addr*13h+a1h. */
`default_nettype none
module tb_top
	import boot_resp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int FB = 8;
	localparam logic [503:0] FIX = {128'hf4fe080000040000ff6b0000ff830000,
		80'h00000000000000000000, 64'h00000100ffff0800, 16'h0a00,
		72'h000001000080000006, 72'h000007000070000002,
		72'h00c008000010000002};
	logic ref_clk = 0, reset = 1, rx_valid = 0, rx_error = 0, tx_ready = 1;
	logic any_protected = 0, ok_in = 1;
	logic [7:0] rx_data = 0, dly = 8'h03, tx_data, flash_rd_data;
	logic rx_ready, tx_valid, flash_rd_en, erase_start, erase_done, erase_ok;
	logic [FLASH_ADDR_W-1:0] flash_addr;
	int n_fail = 0, comparisons = 0, cyc = 0;
	boot_serial_responder #(.FLASH_BYTES(FB)) dut (.ref_clk(ref_clk),
		.reset(reset), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_error(rx_error), .rx_ready(rx_ready), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .flash_addr(flash_addr),
		.flash_rd_en(flash_rd_en), .flash_rd_data(flash_rd_data),
		.erase_start(erase_start), .erase_done(erase_done),
		.erase_ok(erase_ok), .any_protected(any_protected));
	flash_erase_model fm (.ref_clk(ref_clk), .flash_addr(flash_addr),
		.flash_rd_en(flash_rd_en), .flash_rd_data(flash_rd_data),
		.erase_start(erase_start), .ok_in(ok_in), .delay(dly),
		.erase_done(erase_done), .erase_ok(erase_ok));
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end
	function automatic logic [7:0] fb(input logic [18:0] a);
		return a[7:0] * 8'h13 + 8'ha1;
	endfunction
	task summarize;
		$display("fails %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task send(input logic [7:0] d, input logic e);
		@(posedge ref_clk);
		rx_data <= d;
		rx_valid <= 1;
		rx_error <= e;
		do @(negedge ref_clk); while (rx_ready !== 1'b1);
		@(posedge ref_clk);
		rx_valid <= 0;
		rx_error <= ~e;
		rx_data <= ~d;
	endtask
	task get(output logic [7:0] b);
		do @(negedge ref_clk); while (!(tx_valid === 1'b1 && tx_ready));
		b = tx_data;
	endtask
	task expb(input logic [7:0] e);
		logic [7:0] b;
		get(b);
		chk(b, e);
	endtask
	task t_mode;
		send(CMD_SUM, 0);
		send(MODE_BYTE, 1);
		repeat (3) @(negedge ref_clk);
		chk({7'h00, tx_valid}, 8'h00);
		send(MODE_BYTE, 0);
		expb(MODE_BYTE);
		send(8'h55, 0);
		expb(8'h01);
		send(CMD_SUM, 1);
		expb(8'h08);
		send(MODE_BYTE, 0);
		expb(8'h01);
	endtask
	task t_sum;
		logic [15:0] s;
		logic [7:0] h, l, c;
		s = 0;
		for (int i = 0; i < FB; i++)
			s += fb(19'(i));
		send(CMD_SUM, 0);
		expb(CMD_SUM);
		get(h);
		get(l);
		get(c);
		chk(h, s[15:8]);
		chk(l, s[7:0]);
		chk(c, 8'h00 - s[15:8] - s[7:0]);
		chk(h + l + c, 8'h00);
		send(8'h10, 0);
		expb(8'h21);
		send(8'h10, 1);
		expb(8'h28);
	endtask
	task t_info(input logic p);
		logic [7:0] g[0:79];
		logic [7:0] ex[0:78];
		logic [7:0] s;
		s = 0;
		for (int k = 0; k < 79; k++)
			ex[k] = k < 4 ? fb(ID_OFFSET[18:0] + 19'(k)) : k < 16 ?
				PRODUCT_NAME[95 - 8 * (k - 4) -: 8] : FIX[503 - 8 * (k - 16) -: 8];
		send(CMD_INFO, 0);
		any_protected <= p;
		tx_ready <= 0;
		repeat (12) @(posedge ref_clk);
		tx_ready <= 1;
		expb(CMD_INFO);
		for (int k = 0; k < 80; k++)
			get(g[k]);
		ex[41] = p ? PROT_ANY : PROT_NONE;
		for (int k = 0; k < 79; k++)
			s += ex[k];
		for (int k = 0; k < 41; k++)
			chk(g[k], ex[k]);
		for (int k = 42; k < 79; k++)
			chk(g[k], ex[k]);
		chk(g[15], 8'h20);
		chk(g[41], p ? PROT_ANY : PROT_NONE);
		chk(g[79], 8'h00 - s);
	endtask
	task t_erase(input logic ok, input logic [7:0] d);
		send(CMD_ERASE, 0);
		ok_in <= ok;
		dly <= d;
		expb(CMD_ERASE);
		expb(ok ? ERASE_END : ERASE_FAIL);
		expb(ok ? ERASE_ACK_OK : ERASE_ACK_ERR);
		send(8'h77, 0);
		expb(8'h41);
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		reset <= 0;
		t_mode();
		t_sum();
		t_info(1);
		t_info(0);
		t_erase(1, 8'h03);
		t_erase(0, 8'h28);
		summarize();
	end
endmodule // tb_top
`default_nettype wire
